// file: rtl/prsd_pkg.sv
// constants and types of the reference select and divider block
package prsd_pkg;
	localparam logic [7:0] PRSD_ADDR_R_LO = 8'h11;
	localparam logic [7:0] PRSD_ADDR_R_HI = 8'h12;
	localparam logic [7:0] PRSD_ADDR_PRESC = 8'h16;
	localparam logic [7:0] PRSD_ADDR_BIAS = 8'h18;
	localparam logic [7:0] PRSD_ADDR_SYNC = 8'h19;
	localparam logic [7:0] PRSD_ADDR_MON = 8'h1b;
	localparam logic [7:0] PRSD_ADDR_REFSEL = 8'h1c;
	localparam logic [7:0] PRSD_ADDR_CNT = 8'h1d;
	localparam logic [7:0] PRSD_ADDR_A = 8'h13;
	localparam logic [7:0] PRSD_ADDR_B_LO = 8'h14;
	localparam logic [7:0] PRSD_ADDR_B_HI = 8'h15;
	localparam logic [7:0] PRSD_RST_REG = 8'h00;
	// fields of the reference select control register
	localparam int PRSD_SEL_DIFF = 0;
	localparam int PRSD_SEL_PRIMARY_REFERENCE_EN = 1;
	localparam int PRSD_SEL_SECONDARY_REFERENCE_EN = 2;
	localparam int PRSD_SEL_MANUAL_SECONDARY_REFERENCE = 3;
	localparam int PRSD_SEL_USE_PIN = 4;
	localparam int PRSD_SEL_AUTO = 5;
	localparam int PRSD_SEL_PREFER_SECONDARY_REFERENCE = 6;
	localparam int PRSD_SEL_DEGLITCH = 7;
	// fields of the counter control register
	localparam int PRSD_CNT_RST_AB = 0;
	localparam int PRSD_CNT_RST_RAB = 1;
	localparam int PRSD_CNT_PLL_PD = 2;
	localparam int PRSD_CNT_XTAL = 3;
	localparam int PRSD_CNT_DOUBLER = 4;
	localparam int PRSD_CNT_STATUS_SW = 5;
	localparam int PRSD_CNT_PD_PRIMARY_REFERENCE = 6;
	localparam int PRSD_CNT_PD_SECONDARY_REFERENCE = 7;
	localparam int PRSD_BIAS_LOW = 7;
	localparam int PRSD_SYNC_EN_HI = 7;
	localparam int PRSD_SYNC_EN_LO = 6;
	localparam int PRSD_R_W = 14;
	localparam int PRSD_B_W = 13;
	localparam int PRSD_A_W = 6;
	localparam logic [2:0] PRSD_SYNC_CNT = 3'h1;
	// synchroniser reset value: sync pin idles high, so no false edge
	localparam logic [6:0] PRSD_PIN_IDLE = 7'h02;
	typedef enum logic [2:0] {
		PRSD_FD1 = 3'h0, PRSD_DM2 = 3'h1, PRSD_DM4 = 3'h2, PRSD_DM8 = 3'h3,
		PRSD_DM16 = 3'h4, PRSD_DM32 = 3'h5, PRSD_FD2 = 3'h6, PRSD_FD3 = 3'h7
	} prsd_presc_type;
	typedef enum logic [1:0] {
		PRSD_ST_RUN = 2'h0, PRSD_ST_HOLD = 2'h1, PRSD_ST_WAIT = 2'h2
	} prsd_sw_type;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} prsd_bus_type;
	typedef struct packed {
		logic diff_pd_n;
		logic primary_reference_pd_n;
		logic secondary_reference_pd_n;
		logic xtal_amp_en;
		logic bias_low;
		logic doubler_en;
	} prsd_ana_type;
	typedef struct packed {
		logic [7:0] r_lo, r_hi, presc, bias, sync, mon, refsel, cnt, a, b_lo,
			b_hi;
		logic secondary_reference_sel;
		prsd_sw_type sw;
		logic [2:0] sync_pipe;
		logic [PRSD_R_W-1:0] r_cnt;
		logic r_out;
		logic [PRSD_B_W-1:0] b_cnt;
		logic [PRSD_A_W-1:0] a_cnt;
		logic [5:0] p_cnt;
		logic n_out;
		logic [7:0] rdata;
		prsd_ana_type ana;
	} prsd_state_type;
endpackage

// file: rtl/prsd_core.sv
// reference select, switchover, and R / N dividers of the PLL
// Function
// (R1) all reference inputs come out of reset disabled
// (R2) reference type follows the control register at 0x1c
// (R3) optional doubler of the reference frequency
// (R4) bit 7 of 0x18 lowers single-ended bias offset
// (R5) single-ended buffers off on pll down, own power down, or diff mode
// (R6) differential receiver off unless selected and pll powered
// (R7) crystal amplifier runs only with its enable bit
// (R8) manual ref choice by register or by the select pin
// (R9) host ensures target clock present or disables deglitch first
// (R10) revertive auto switch: monitor high selects secondary, low returns
// (R11) status pin may command switch; secondary may be preferred
// (R12) deglitch blocks misaligned edges after a switch; bit 7 clears it
// (R13) no nonrevertive automatic mode exists
// (R14) 14-bit reference divider, 0 and 1 divide by one
// (R15) R output and N output feed the detector inputs
// (R16) R divider reset by shared bit and by sync
// (R17) feedback ratio is P times B plus A
// (R18) prescaler modes FD 1/2/3 and DM 2..32 from 0x16[2:0]
// (R19) fixed divide modes ignore A
// (R20) ratios from 1 up to 262175 reachable
// (R21) host keeps B at least 3 or bypass, A not above B
// (R22) B of one bypasses, ratio is the prescaler alone
// (R23) dedicated A/B reset plus shared reset, neither self-clearing
// (R24) sync pin reset gated by 0x19[7:6], off after reset
// (R25) counters held at start count while reset bits set
`timescale 1ns/1ps
module prsd_core
	import prsd_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire prsd_bus_type i_bus,
	output logic [7:0] o_rdata,
	input wire logic i_primary_reference_clk,
	input wire logic i_secondary_reference_clk,
	input wire logic i_ref_sel_pin,
	input wire logic i_ref_monitor_pin,
	input wire logic i_status_pin,
	input wire logic i_sync_n,
	input wire logic i_fb_clk,
	output logic o_ref_active2,
	output logic o_pfd_ref,
	output logic o_pfd_fb,
	output prsd_ana_type o_ana
);
	prsd_state_type q, d;
	// two-stage synchronisers for every pin input
	logic [6:0] s1_q, s2_q, s3_q;
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s1_q <= PRSD_PIN_IDLE;
			s2_q <= PRSD_PIN_IDLE;
			s3_q <= PRSD_PIN_IDLE;
		end else begin
			s1_q <= {i_primary_reference_clk, i_secondary_reference_clk, i_ref_sel_pin, i_ref_monitor_pin,
				i_status_pin, i_sync_n, i_fb_clk};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	logic primary_reference_s, secondary_reference_s, sel_s, mon_s, stat_s, sync_n_s, fb_s;
	logic primary_reference_p, secondary_reference_p, fb_p;
	assign {primary_reference_s, secondary_reference_s, sel_s, mon_s, stat_s, sync_n_s, fb_s} = s2_q;
	assign primary_reference_p = s3_q[6];
	assign secondary_reference_p = s3_q[5];
	assign fb_p = s3_q[0];

	function automatic logic [5:0] presc_val(input logic [2:0] m);
		case (m)
			PRSD_FD1: presc_val = 6'h01;
			PRSD_DM2: presc_val = 6'h02;
			PRSD_DM4: presc_val = 6'h04;
			PRSD_DM8: presc_val = 6'h08;
			PRSD_DM16: presc_val = 6'h10;
			PRSD_DM32: presc_val = 6'h20;
			PRSD_FD2: presc_val = 6'h02;
			PRSD_FD3: presc_val = 6'h03;
			default: presc_val = 6'h01;
		endcase
	endfunction

	function automatic logic is_dm(input logic [2:0] m);
		is_dm = (m >= PRSD_DM2) && (m <= PRSD_DM32);
	endfunction

	logic want_secondary_reference, ref_edge, ref_rise, sync_hit, r_hold, ab_hold;
	logic [PRSD_R_W-1:0] r_div;
	logic [PRSD_B_W-1:0] b_div;
	logic [5:0] p_val;
	logic dm, diff_mode;

	always_comb begin
		d = q;
		diff_mode = q.refsel[PRSD_SEL_DIFF];
		dm = is_dm(q.presc[2:0]); // see (R18)
		p_val = presc_val(q.presc[2:0]); // see (R17)
		r_div = {q.r_hi[5:0], q.r_lo};
		b_div = {q.b_hi[4:0], q.b_lo};
		// selection: auto is always revertive, no latch on backup; see (R13)
		if (q.refsel[PRSD_SEL_AUTO]) begin
			// see (R10) (R11)
			want_secondary_reference = (q.cnt[PRSD_CNT_STATUS_SW] ? stat_s : mon_s)
				^ q.refsel[PRSD_SEL_PREFER_SECONDARY_REFERENCE];
		end else if (q.refsel[PRSD_SEL_USE_PIN]) begin
			want_secondary_reference = sel_s; // see (R8)
		end else begin
			want_secondary_reference = q.refsel[PRSD_SEL_MANUAL_SECONDARY_REFERENCE]; // see (R8)
		end
		ref_rise = q.secondary_reference_sel ? (secondary_reference_s & ~secondary_reference_p) : (primary_reference_s & ~primary_reference_p);
		// deglitch: after a change, wait for a low and then a rising edge on new ref, then resume
		case (q.sw)
			PRSD_ST_RUN: begin
				if (want_secondary_reference != q.secondary_reference_sel) begin
					d.secondary_reference_sel = want_secondary_reference;
					d.sw = q.refsel[PRSD_SEL_DEGLITCH] ? PRSD_ST_HOLD
						: PRSD_ST_RUN; // see (R12)
				end
			end
			PRSD_ST_HOLD: begin
				// target clock absent keeps us in HOLD or WAIT until the deglitch bit is cleared; see (R9)
				if (!(q.secondary_reference_sel ? secondary_reference_s : primary_reference_s))
					d.sw = PRSD_ST_WAIT;
				if (!q.refsel[PRSD_SEL_DEGLITCH])
					d.sw = PRSD_ST_RUN;
			end
			PRSD_ST_WAIT: begin
				if (ref_rise || !q.refsel[PRSD_SEL_DEGLITCH])
					d.sw = PRSD_ST_RUN;
			end
			default: d.sw = PRSD_ST_RUN;
		endcase
		// doubler counts both edges; see (R3)
		ref_edge = (q.sw == PRSD_ST_RUN) && !diff_mode ? (ref_rise ||
			(q.cnt[PRSD_CNT_DOUBLER] && (q.secondary_reference_sel ?
			(~secondary_reference_s & secondary_reference_p) : (~primary_reference_s & primary_reference_p)))) : 1'b0;
		if (diff_mode)
			ref_edge = (primary_reference_s & ~primary_reference_p) || (q.cnt[PRSD_CNT_DOUBLER] &&
				(~primary_reference_s & primary_reference_p));
		// sync pin reset only when enabled; see (R24)
		d.sync_pipe = {q.sync_pipe[1:0], ~sync_n_s};
		sync_hit = q.sync_pipe[0] && !q.sync_pipe[1] &&
			q.sync[PRSD_SYNC_EN_HI] && q.sync[PRSD_SYNC_EN_LO];
		r_hold = q.cnt[PRSD_CNT_RST_RAB]; // see (R16) (R23)
		ab_hold = q.cnt[PRSD_CNT_RST_RAB] || q.cnt[PRSD_CNT_RST_AB];
		// reference divider; see (R14) (R15)
		if (r_hold || sync_hit) begin
			d.r_cnt = '0; // see (R25) (R16)
			d.r_out = 1'b0;
		end else if (ref_edge) begin
			if (r_div <= 14'h0001) begin
				d.r_out = 1'b1; // divide by one passes every edge
			end else if (q.r_cnt >= r_div - 14'h0001) begin
				d.r_cnt = '0;
				d.r_out = 1'b1;
			end else begin
				d.r_cnt = q.r_cnt + 14'h0001;
				d.r_out = 1'b0;
			end
		end else begin
			d.r_out = 1'b0;
		end
		// feedback divider N = P*B + A; see (R17) (R19) (R20) (R22)
		// one-cycle pulse, the detector counts edges; see (R15)
		d.n_out = 1'b0;
		if (ab_hold || sync_hit) begin
			d.p_cnt = '0; // see (R25)
			d.b_cnt = '0;
			d.a_cnt = '0;
			d.n_out = 1'b0;
		end else if (fb_s && !fb_p) begin
			d.n_out = 1'b0;
			// one prescaler period lasts P, or P+1 in DM modes while A not exhausted and B is above one
			if (q.p_cnt + 6'h01 >= p_val + {5'h00, dm &&
				(q.a_cnt < q.a[PRSD_A_W-1:0]) && (b_div > 13'h0001)}) begin
				d.p_cnt = '0;
				if (dm && q.a_cnt < q.a[PRSD_A_W-1:0])
					d.a_cnt = q.a_cnt + 6'h01;
				if (b_div <= 13'h0001 ||
					q.b_cnt + 13'h0001 >= b_div) begin
					d.b_cnt = '0;
					d.a_cnt = '0;
					d.n_out = 1'b1;
				end else begin
					d.b_cnt = q.b_cnt + 13'h0001;
				end
			end else begin
				d.p_cnt = q.p_cnt + 6'h01;
			end
		end
		// analog controls; see (R1) (R2) (R4) (R5) (R6) (R7)
		d.ana.diff_pd_n = diff_mode && !q.cnt[PRSD_CNT_PLL_PD];
		d.ana.primary_reference_pd_n = !diff_mode && !q.cnt[PRSD_CNT_PLL_PD] &&
			q.refsel[PRSD_SEL_PRIMARY_REFERENCE_EN] && !q.cnt[PRSD_CNT_PD_PRIMARY_REFERENCE];
		d.ana.secondary_reference_pd_n = !diff_mode && !q.cnt[PRSD_CNT_PLL_PD] &&
			q.refsel[PRSD_SEL_SECONDARY_REFERENCE_EN] && !q.cnt[PRSD_CNT_PD_SECONDARY_REFERENCE];
		d.ana.xtal_amp_en = diff_mode && q.cnt[PRSD_CNT_XTAL];
		d.ana.bias_low = q.bias[PRSD_BIAS_LOW];
		d.ana.doubler_en = q.cnt[PRSD_CNT_DOUBLER];
		// register writes; reset bits stay until written zero
		if (i_bus.wr) begin
			case (i_bus.addr)
				PRSD_ADDR_R_LO: d.r_lo = i_bus.wdata;
				PRSD_ADDR_R_HI: d.r_hi = i_bus.wdata;
				PRSD_ADDR_A: d.a = i_bus.wdata;
				PRSD_ADDR_B_LO: d.b_lo = i_bus.wdata;
				PRSD_ADDR_B_HI: d.b_hi = i_bus.wdata;
				PRSD_ADDR_PRESC: d.presc = i_bus.wdata;
				PRSD_ADDR_BIAS: d.bias = i_bus.wdata;
				PRSD_ADDR_SYNC: d.sync = i_bus.wdata;
				PRSD_ADDR_MON: d.mon = i_bus.wdata;
				PRSD_ADDR_REFSEL: d.refsel = i_bus.wdata;
				PRSD_ADDR_CNT: d.cnt = i_bus.wdata; // see (R23)
				default: d.rdata = q.rdata;
			endcase
		end
		case (i_bus.addr)
			PRSD_ADDR_R_LO: d.rdata = q.r_lo;
			PRSD_ADDR_R_HI: d.rdata = q.r_hi;
			PRSD_ADDR_A: d.rdata = q.a;
			PRSD_ADDR_B_LO: d.rdata = q.b_lo;
			PRSD_ADDR_B_HI: d.rdata = q.b_hi;
			PRSD_ADDR_PRESC: d.rdata = q.presc;
			PRSD_ADDR_BIAS: d.rdata = q.bias;
			PRSD_ADDR_SYNC: d.rdata = q.sync;
			PRSD_ADDR_MON: d.rdata = {q.mon[7:1], q.secondary_reference_sel};
			PRSD_ADDR_REFSEL: d.rdata = q.refsel;
			PRSD_ADDR_CNT: d.rdata = q.cnt;
			default: d.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			q <= '0; // see (R1) (R24)
		else
			q <= d;
	end

	assign o_rdata = q.rdata;
	assign o_ref_active2 = q.secondary_reference_sel;
	assign o_pfd_ref = q.r_out;
	assign o_pfd_fb = q.n_out;
	assign o_ana = q.ana;

	a_diff_pd_rule: assert property (@(posedge i_sys_clk) disable iff
		(!i_arst_n) $past(q.cnt[PRSD_CNT_PLL_PD]) |-> !o_ana.diff_pd_n
		&& !o_ana.primary_reference_pd_n && !o_ana.secondary_reference_pd_n) // see (R5) (R6)
		else $error("reference buffer on while pll down");
	a_se_off_diff: assert property (@(posedge i_sys_clk) disable iff
		(!i_arst_n) $past(q.refsel[PRSD_SEL_DIFF]) |-> !o_ana.primary_reference_pd_n
		&& !o_ana.secondary_reference_pd_n) // see (R5)
		else $error("single-ended buffer on in differential mode");
	a_xtal_gate: assert property (@(posedge i_sys_clk) disable iff
		(!i_arst_n) !$past(q.cnt[PRSD_CNT_XTAL]) |-> !o_ana.xtal_amp_en)
		// see (R7)
		else $error("crystal amplifier on without enable");
	a_bias_follow: assert property (@(posedge i_sys_clk) disable iff
		(!i_arst_n) o_ana.bias_low == $past(q.bias[PRSD_BIAS_LOW])) // see (R4)
		else $error("bias option not following register");
	a_r_hold_quiet: assert property (@(posedge i_sys_clk) disable iff
		(!i_arst_n) q.cnt[PRSD_CNT_RST_RAB] ##1 q.cnt[PRSD_CNT_RST_RAB]
		|-> !o_pfd_ref && q.r_cnt == '0) // see (R25) (R16)
		else $error("reference divider moves under reset");
	a_ab_hold_quiet: assert property (@(posedge i_sys_clk) disable iff
		(!i_arst_n) q.cnt[PRSD_CNT_RST_AB] ##1 q.cnt[PRSD_CNT_RST_AB]
		|-> !o_pfd_fb && q.b_cnt == '0) // see (R23) (R25)
		else $error("feedback divider moves under reset");
	a_manual_reg: assert property (@(posedge i_sys_clk) disable iff
		(!i_arst_n) (q.sw == PRSD_ST_RUN && !q.refsel[PRSD_SEL_AUTO] &&
		!q.refsel[PRSD_SEL_USE_PIN] && !i_bus.wr)[*2]
		|-> q.secondary_reference_sel == q.refsel[PRSD_SEL_MANUAL_SECONDARY_REFERENCE]) // see (R8)
		else $error("manual selection not applied");
	a_sync_gated: assert property (@(posedge i_sys_clk) disable iff
		(!i_arst_n) !q.sync[PRSD_SYNC_EN_HI] && ref_edge && !r_hold &&
		r_div > 14'h0001 && q.r_cnt < r_div - 14'h0001
		|=> q.r_cnt == $past(q.r_cnt) + 14'h0001) // see (R24) (R14)
		else $error("sync reset acted while disabled");

	// a two-cycle reset hold and a one-cycle switch request, used by the properties below
	sequence s_rab_held;
		q.cnt[PRSD_CNT_RST_RAB] ##1 q.cnt[PRSD_CNT_RST_RAB];
	endsequence
	sequence s_switch_req;
		q.sw == PRSD_ST_RUN && want_secondary_reference != q.secondary_reference_sel &&
			q.refsel[PRSD_SEL_DEGLITCH];
	endsequence

	a_rpulse_once: assert property // see (R15)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_pfd_ref |=> !o_pfd_ref)
		else $error("reference pulse wider than one cycle");

	a_npulse_once: assert property // see (R15)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_pfd_fb |=> !o_pfd_fb)
		else $error("feedback pulse wider than one cycle");

	a_rdiv_one: assert property // see (R14)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		r_div <= 14'h0001 && ref_edge && !r_hold && !sync_hit
		|=> o_pfd_ref)
		else $error("divide by one dropped a reference edge");

	a_ab_rab_hold: assert property // see (R16) (R23)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		s_rab_held |-> !o_pfd_fb && q.b_cnt == '0 && q.a_cnt == '0)
		else $error("feedback divider moves under shared reset");

	a_diff_rx_off: assert property // see (R6)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		!$past(q.refsel[PRSD_SEL_DIFF]) |-> !o_ana.diff_pd_n)
		else $error("differential receiver on while not selected");

	a_primary_reference_pd_own: assert property // see (R5)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		$past(q.cnt[PRSD_CNT_PD_PRIMARY_REFERENCE]) |-> !o_ana.primary_reference_pd_n)
		else $error("primary buffer on despite its power down");

	a_secondary_reference_pd_own: assert property // see (R5)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		$past(q.cnt[PRSD_CNT_PD_SECONDARY_REFERENCE]) |-> !o_ana.secondary_reference_pd_n)
		else $error("secondary buffer on despite its power down");

	a_inputs_idle: assert property // see (R1)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		$past(q.refsel[2:0]) == 3'h0 |-> !o_ana.diff_pd_n &&
		!o_ana.primary_reference_pd_n && !o_ana.secondary_reference_pd_n)
		else $error("reference input on without enable");

	a_doubler_follow: assert property // see (R3)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_ana.doubler_en == $past(q.cnt[PRSD_CNT_DOUBLER]))
		else $error("doubler not following register");

	a_auto_follow: assert property // see (R10) (R13)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		q.refsel[PRSD_SEL_AUTO] && q.sw == PRSD_ST_RUN
		|=> q.secondary_reference_sel == $past(want_secondary_reference))
		else $error("automatic selection not following command");

	a_deglitch_gate: assert property // see (R12)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		q.sw != PRSD_ST_RUN && !diff_mode |-> !ref_edge)
		else $error("reference edge passed during deglitch");

	a_deglitch_off: assert property // see (R12)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		!q.refsel[PRSD_SEL_DEGLITCH] |=> q.sw == PRSD_ST_RUN)
		else $error("deglitch active while disabled");

	a_switch_hold: assert property // see (R12)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		s_switch_req |=> q.sw == PRSD_ST_HOLD &&
		q.secondary_reference_sel == $past(want_secondary_reference))
		else $error("switch did not enter deglitch hold");

	a_sync_clear: assert property // see (R24) (R16)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		sync_hit |=> q.r_cnt == '0 && q.b_cnt == '0 && !o_pfd_ref)
		else $error("sync did not restart the counters");

	a_fd_a_idle: assert property // see (R19)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		!dm && q.a_cnt == '0 |=> q.a_cnt == '0)
		else $error("a counter moved in fixed divide mode");

	// crystal amplifier rides on the differential receiver pins
	a_xtal_diff: assert property // see (R7)
		(@(posedge i_sys_clk) disable iff (!i_arst_n)
		o_ana.xtal_amp_en |-> $past(q.refsel[PRSD_SEL_DIFF]))
		else $error("crystal amplifier on outside crystal mode");
endmodule

// file: dv/prsd_ref_src.sv
// free-running reference and feedback clock sources for the divider block
`timescale 1ns/1ps
module prsd_ref_src #(
	parameter int HALF1 = 40,
	parameter int HALF2 = 45,
	parameter int HALFF = 30
) (
	output logic o_primary_reference,
	output logic o_secondary_reference,
	output logic o_fb
);
	// both references run free so a switch always finds a clock
	initial begin
		o_primary_reference = 1'b0;
		#3;
		forever #(HALF1) o_primary_reference = ~o_primary_reference;
	end
	initial begin
		o_secondary_reference = 1'b0;
		#7;
		forever #(HALF2) o_secondary_reference = ~o_secondary_reference;
	end
	// periods kept above four system cycles, as the synchronisers need
	initial begin
		o_fb = 1'b0;
		#2;
		forever #(HALFF) o_fb = ~o_fb;
	end
endmodule

// file: dv/test_prsd_core.sv
// self-checking testbench of the reference select and divider block
`timescale 1ns/1ps
module test_prsd_core
	import prsd_pkg::*;
;
	logic clk, rst_n, sel_pin, mon_pin, stat_pin, sync_n, act2;
	logic pfd_r, pfd_f, r1, r2, fb;
	logic [7:0] rdata;
	prsd_bus_type bus;
	prsd_ana_type ana;
	int n_errors, num_checks, cyc;
	logic [7:0] regs [6] = '{PRSD_ADDR_R_LO, PRSD_ADDR_R_HI, PRSD_ADDR_PRESC,
		PRSD_ADDR_BIAS, PRSD_ADDR_MON, PRSD_ADDR_REFSEL};
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	prsd_ref_src src (.o_primary_reference(r1), .o_secondary_reference(r2), .o_fb(fb));
	prsd_core dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_bus(bus),
		.o_rdata(rdata), .i_primary_reference_clk(r1), .i_secondary_reference_clk(r2),
		.i_ref_sel_pin(sel_pin), .i_ref_monitor_pin(mon_pin),
		.i_status_pin(stat_pin), .i_sync_n(sync_n), .i_fb_clk(fb),
		.o_ref_active2(act2), .o_pfd_ref(pfd_r), .o_pfd_fb(pfd_f),
		.o_ana(ana));
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// expected run is about 10k cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic chk8(string s, logic [7:0] e, logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chkn(string s, int e, int g);
		num_checks++;
		if (g != e) begin
			n_errors++;
			$display("ERROR %s expected %0d seen %0d", s, e, g);
		end
	endtask
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	// one idle cycle between writes so wr never moves twice in a step
	task automatic wr(logic [7:0] a, logic [7:0] d);
		tick();
		bus = '{1'b1, a, d};
		tick();
		bus.wr = 1'b0;
	endtask
	task automatic rd(logic [7:0] a, output logic [7:0] d);
		tick();
		bus.addr = a;
		tick();
		tick();
		d = rdata;
	endtask
	task automatic an(logic [7:0] s, logic [7:0] c, logic [7:0] b,
		logic [5:0] e);
		wr(PRSD_ADDR_REFSEL, s);
		wr(PRSD_ADDR_CNT, c);
		wr(PRSD_ADDR_BIAS, b);
		repeat (3) tick();
		chk8("ana", {2'h0, e}, {2'h0, ana});
	endtask
	task automatic wact(logic e);
		int k;
		k = 0;
		while (act2 !== e && k < 200) begin
			tick();
			k++;
		end
		chk8("ref_active2", {7'h0, e}, {7'h0, act2});
	endtask
	// sync falling edge every 100 cycles, so an R of 20 never completes
	task automatic sy(output int n);
		int k;
		n = 0;
		repeat (7) begin
			sync_n = 1'b0;
			cnt(1'b0, 50, k);
			n += k;
			sync_n = 1'b1;
			cnt(1'b0, 50, k);
			n += k;
		end
	endtask
	task automatic cnt(bit f, int c, output int n);
		n = 0;
		repeat (c) begin
			tick();
			if ((f ? pfd_f : pfd_r) === 1'b1)
				n++;
		end
	endtask
	// gap between the second and third pulses, so a partial first period is skipped
	task automatic per(bit f, output int p);
		repeat (3) begin
			p = 0;
			do begin
				tick();
				p++;
			end while ((f ? pfd_f : pfd_r) !== 1'b1 && p < 3000);
		end
	endtask
	function automatic int nexp(logic [2:0] m, int a, int b);
		int p;
		case (m)
			3'h0: p = 1;
			3'h6: p = 2;
			3'h7: p = 3;
			default: p = 2 << (m - 1);
		endcase
		if (b == 1)
			return p;
		return (m == 3'h0 || m > 3'h5) ? p * b : p * b + a;
	endfunction
	initial begin
		logic [7:0] d, v;
		int p, n, r, a, b;
		bus = '0;
		{sel_pin, mon_pin, stat_pin, rst_n} = 4'h0;
		sync_n = 1'b1;
		{n_errors, num_checks, cyc} = '0;
		void'($urandom(56989));
		repeat (3) @(posedge clk);
		#1 rst_n = 1'b1;
		chk8("ana_reset", 8'h00, {2'h0, ana});
		foreach (regs[i]) begin
			rd(regs[i], d);
			chk8("reg_reset", 8'h00, d);
			v = 8'($urandom);
			wr(regs[i], v);
			rd(regs[i], d);
			// bit 0 of the monitor register shows the live selection
			if (regs[i] == PRSD_ADDR_MON)
				v[0] = 1'b0;
			chk8("reg_rw", v, d);
		end
		rd(8'h05, d);
		chk8("unmapped", 8'h00, d);
		$display("done: registers");
		an(8'h01, 8'h00, 8'h00, 6'h20);
		an(8'h06, 8'h00, 8'h00, 6'h18);
		an(8'h06, 8'h40, 8'h00, 6'h08);
		an(8'h06, 8'h04, 8'h00, 6'h00);
		an(8'h01, 8'h08, 8'h00, 6'h24);
		an(8'h06, 8'h10, 8'h80, 6'h1b);
		an(8'h06, 8'h00, 8'h00, 6'h18);
		$display("done: reference inputs");
		wr(PRSD_ADDR_REFSEL, 8'h16);
		sel_pin = 1'b1;
		wact(1'b1);
		sel_pin = 1'b0;
		wact(1'b0);
		wr(PRSD_ADDR_MON, 8'hf7);
		wr(PRSD_ADDR_REFSEL, 8'h26);
		mon_pin = 1'b1;
		wact(1'b1);
		mon_pin = 1'b0;
		wact(1'b0);
		wr(PRSD_ADDR_CNT, 8'h20);
		stat_pin = 1'b1;
		wact(1'b1);
		stat_pin = 1'b0;
		wact(1'b0);
		$display("done: switchover");
		wr(PRSD_ADDR_CNT, 8'h00);
		wr(PRSD_ADDR_REFSEL, 8'h06);
		for (int i = 0; i < 4; i++) begin
			r = (i < 2) ? i : 2 + $urandom % 4;
			wr(PRSD_ADDR_R_LO, 8'(r));
			wr(PRSD_ADDR_R_HI, 8'h00);
			per(1'b0, p);
			chkn("r_period", (r < 2 ? 1 : r) * 8, p);
		end
		// manual switch to secondary with deglitch on
		wr(PRSD_ADDR_REFSEL, 8'h8e);
		wact(1'b1);
		per(1'b0, p);
		chkn("deglitch_period", (r < 2 ? 1 : r) * 9, p);
		wr(PRSD_ADDR_REFSEL, 8'h06);
		wact(1'b0);
		$display("done: reference divider");
		for (int j = 0; j < 16; j++) begin
			// host keeps b at 3 or more, or at 1 for bypass, and a not above b
			b = (j > 7) ? 1 : 3 + $urandom % 2;
			a = (j > 7) ? 0 : $urandom % (b + 1);
			wr(PRSD_ADDR_A, 8'(a));
			wr(PRSD_ADDR_B_LO, 8'(b));
			wr(PRSD_ADDR_B_HI, 8'h00);
			wr(PRSD_ADDR_PRESC, 8'(j % 8));
			per(1'b1, p);
			chkn("n_period", nexp(3'(j), a, b) * 6, p);
		end
		$display("done: feedback divider");
		wr(PRSD_ADDR_CNT, 8'h01);
		cnt(1'b1, 200, n);
		chkn("fb_held", 0, n);
		cnt(1'b0, 200, n);
		chkn("ref_runs", 1, int'(n > 0));
		wr(PRSD_ADDR_CNT, 8'h02);
		cnt(1'b0, 200, n);
		chkn("ref_held", 0, n);
		wr(PRSD_ADDR_CNT, 8'h00);
		cnt(1'b1, 200, n);
		chkn("fb_resumes", 1, int'(n > 0));
		wr(PRSD_ADDR_R_LO, 8'h14);
		wr(PRSD_ADDR_SYNC, 8'hc0);
		sync_n = 1'b0;
		sy(n);
		chkn("sync_reset", 0, n);
		wr(PRSD_ADDR_SYNC, 8'h00);
		sy(n);
		chkn("sync_gated", 1, int'(n > 0));
		$display("done: counter resets");
		print_verdict();
	end
endmodule
